/* File: rtl/slbrs_top.sv */
`timescale 1ns/1ps
// Behaviour
// - BREAK_CLEAR_ENABLE clear blocks flag clearing in break
// - BREAK_CLEAR_ENABLE set lets break clears stick
// - two-step flags stay protected through break while BREAK_CLEAR_ENABLE clear
// - wait or stop clears interrupt mask
// - wait stops core clock, peripherals run
// - wait interrupt starts stacking next cycle
// - reset or break ends wait; break sets flag
// - watchdog runs in wait unless disabled
// - stop clears counter, gates base clock
// - stop ends on irq or break after recovery, on reset at once
// - recovery 4096 or 32 oscillator cycles
// - counter held in stop, counts during recovery
// - break in stop sets exit flag
// - exit flag cleared by write zero, reset
// - reading cause register clears all cause flags except any set in the same cycle
// - cause flags stay until register read
// - power-on sets POR flag, clears others
// - one cause flag records each reset
// - internal resets drive reset pin low
module slbrs_top
  import slbrs_pkg::*;
(
  input  wire logic           CLK,
  input  wire logic           RST,
  input  wire slbrs_axi_req_t AXI_REQ,
  output slbrs_axi_rsp_t      AXI_RSP,
  input  wire logic           WAIT_EXEC,
  input  wire logic           STOP_EXEC,
  input  wire logic           MOD_IRQ,
  input  wire logic           BRK_IRQ,
  input  wire logic           BRK_MODE,
  input  wire logic           SHORT_RECOV_SEL,
  input  wire logic           WDOG_DISABLE,
  input  wire logic           RST_PIN_I,
  input  wire logic           WDOG_RST,
  input  wire logic           BAD_OPCODE,
  input  wire logic           BAD_FETCH,
  input  wire logic           LOW_VOLT,
  output logic                FLAG_CLR_ALLOW,
  output logic                CPU_CLK_EN,
  output logic                BASE_CLK_EN,
  output logic                CLR_IMASK,
  output logic                STACK_GO,
  output logic                WDOG_RUN,
  output logic                RST_PIN_O,
  output logic                RST_PIN_OE
);

  slbrs_st_t q;
  slbrs_st_t n;

  function automatic logic strb_ok(input logic [3:0] s);
    strb_ok = s[0];
  endfunction

  logic        int_rst;
  logic        pin_rst;
  logic        any_rst;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  cause_set;

  always_comb
  begin
    int_rst = WDOG_RST | BAD_OPCODE | BAD_FETCH | LOW_VOLT;
    // Own pull-down echoes back through the synchroniser; mask it
    pin_rst = q.pin_s2 & (q.pull == 6'h00);
    any_rst = int_rst | pin_rst;
    wr_go   = q.aw_held & q.w_held & ~q.rsp.bvalid;
    rd_go   = AXI_REQ.arvalid & q.rsp.arready;
    // Priority picks a single cause when several fire together
    cause_set = 8'h00;
    if (pin_rst)
      cause_set[CA_PIN] = 1'b1;
    else if (WDOG_RST)
      cause_set[CA_WDOG] = 1'b1;
    else if (BAD_OPCODE)
      cause_set[CA_OPC] = 1'b1;
    else if (BAD_FETCH)
      cause_set[CA_FETCH] = 1'b1;
    else if (LOW_VOLT)
      cause_set[CA_LV] = 1'b1;

    n = q;
    n.pin_s1    = ~RST_PIN_I;
    n.pin_s2    = q.pin_s1;
    n.clr_imask = 1'b0;
    n.stack_go  = 1'b0;

    // Low-power sequencing
    case (q.lp)
      LP_RUN:
      begin
        if (!any_rst && WAIT_EXEC)
        begin
          n.lp        = LP_WAIT;
          n.clr_imask = 1'b1;
        end
        else if (!any_rst && STOP_EXEC)
        begin
          n.lp        = LP_STOP;
          n.clr_imask = 1'b1;
          n.cnt       = 12'h000;
        end
      end
      LP_WAIT:
      begin
        if (any_rst)
          n.lp = LP_RUN;
        else if (BRK_IRQ || MOD_IRQ)
        begin
          n.lp       = LP_RUN;
          n.stack_go = 1'b1;
        end
      end
      LP_STOP:
      begin
        n.cnt = 12'h000;
        if (any_rst)
          n.lp = LP_RUN;
        else if (BRK_IRQ || MOD_IRQ)
        begin
          n.lp        = LP_RECOV;
          // Short delay only suits canned oscillators
          n.lim_short = SHORT_RECOV_SEL;
          n.wake_irq  = 1'b1;
        end
      end
      LP_RECOV:
      begin
        n.cnt = q.cnt + 12'h001;
        if (any_rst)
          n.lp = LP_RUN;
        else if (q.cnt == (q.lim_short ? RECOV_SHORT_LAST
                                        : RECOV_LONG_LAST))
        begin
          n.lp       = LP_RUN;
          n.stack_go = q.wake_irq;
          n.wake_irq = 1'b0;
        end
      end
      default:
        n.lp = LP_RUN;
    endcase

    n.cpu_clk_en  = (n.lp == LP_RUN);
    n.base_clk_en = (n.lp == LP_RUN) || (n.lp == LP_WAIT);
    n.wdog_run    = ~WDOG_DISABLE && (n.lp != LP_STOP)
                    && (n.lp != LP_RECOV);
    // With break_clear_enable clear, peripherals keep any half-done two-step clear pending in break
    n.clr_allow   = ~BRK_MODE | q.break_clear_enable;

    // Reset pin pull-down for internal sources
    if (int_rst)
      n.pull = PIN_PULL_LOAD;
    else if (q.pull != 6'h00)
      n.pull = q.pull - 6'h01;
    n.rst_oe = (n.pull > PIN_OE_TAIL);

    // Bus write channel
    if (AXI_REQ.awvalid && q.rsp.awready)
    begin
      n.aw_held = 1'b1;
      n.aw_addr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && q.rsp.wready)
    begin
      n.w_held = 1'b1;
      n.w_data = AXI_REQ.wdata;
      n.w_strb = AXI_REQ.wstrb;
    end
    if (wr_go)
    begin
      n.aw_held    = 1'b0;
      n.w_held     = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = RESP_OKAY;
      if (q.aw_addr == ADDR_BRK_CTRL && strb_ok(q.w_strb))
        n.break_clear_enable = q.w_data[BIT_BREAK_CLEAR_ENABLE];
      else if (q.aw_addr == ADDR_BRK_STAT && strb_ok(q.w_strb))
      begin
        if (!q.w_data[BIT_BRK_EXIT])
          n.exit_flag = 1'b0;
      end
      else if (q.aw_addr != ADDR_RST_CAUSE)
        n.rsp.bresp = RESP_SLVERR;
    end
    else if (q.rsp.bvalid && AXI_REQ.bready)
      n.rsp.bvalid = 1'b0;
    n.rsp.awready = ~n.aw_held & ~n.rsp.bvalid;
    n.rsp.wready  = ~n.w_held & ~n.rsp.bvalid;

    // Bus read channel
    if (rd_go)
    begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = RESP_OKAY;
      n.rsp.rdata  = 32'h0000_0000;
      case (AXI_REQ.araddr)
        ADDR_BRK_STAT:
          n.rsp.rdata[BIT_BRK_EXIT] = q.exit_flag;
        ADDR_RST_CAUSE:
        begin
          n.rsp.rdata[7:0] = q.cause;
          n.cause          = 8'h00;
        end
        ADDR_BRK_CTRL:
          n.rsp.rdata[BIT_BREAK_CLEAR_ENABLE] = q.break_clear_enable;
        default:
          n.rsp.rresp = RESP_SLVERR;
      endcase
    end
    else if (q.rsp.rvalid && AXI_REQ.rready)
      n.rsp.rvalid = 1'b0;
    n.rsp.arready = ~n.rsp.rvalid;

    // Set wins over clear; flags held until read
    n.cause = n.cause | cause_set;
    // Break ends a low-power mode; a running break leaves the flag
    if (BRK_IRQ && !any_rst &&
        (q.lp == LP_WAIT || q.lp == LP_STOP))
      n.exit_flag = 1'b1;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      q             <= '0;
      q.lp          <= LP_RUN;
      q.cause       <= RST_CAUSE_VAL;
      q.exit_flag   <= RST_EXIT_VAL;
      q.break_clear_enable        <= RST_BREAK_CLEAR_ENABLE_VAL;
      q.clr_allow   <= 1'b1;
      q.cpu_clk_en  <= 1'b1;
      q.base_clk_en <= 1'b1;
    end
    else
      q <= n;
  end

  assign AXI_RSP        = q.rsp;
  assign FLAG_CLR_ALLOW = q.clr_allow;
  assign CPU_CLK_EN     = q.cpu_clk_en;
  assign BASE_CLK_EN    = q.base_clk_en;
  assign CLR_IMASK      = q.clr_imask;
  assign STACK_GO       = q.stack_go;
  assign WDOG_RUN       = q.wdog_run;
  assign RST_PIN_O      = 1'b0;
  assign RST_PIN_OE     = q.rst_oe;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  brk_protect_a: assert property (
    BRK_MODE && !q.break_clear_enable |=> !FLAG_CLR_ALLOW)
    else $error("flag clear allowed in break");

  run_clr_a: assert property (
    !BRK_MODE |=> FLAG_CLR_ALLOW)
    else $error("flag clear blocked outside break");

  brk_clear_ok_a: assert property (
    q.break_clear_enable |=> FLAG_CLR_ALLOW)
    else $error("flag clear blocked with enable set");

  break_clear_enable_wr_a: assert property (
    wr_go && q.aw_addr == ADDR_BRK_CTRL && strb_ok(q.w_strb)
    |=> q.break_clear_enable == $past(q.w_data[BIT_BREAK_CLEAR_ENABLE]))
    else $error("clear enable write lost");

  imask_clr_a: assert property (
    q.lp == LP_RUN && WAIT_EXEC && !any_rst
    |=> CLR_IMASK && !CPU_CLK_EN && BASE_CLK_EN)
    else $error("wait entry wrong");

  imask_pulse_a: assert property (
    CLR_IMASK |=> !CLR_IMASK)
    else $error("mask clear longer than one cycle");

  stop_entry_a: assert property (
    q.lp == LP_RUN && STOP_EXEC && !WAIT_EXEC && !any_rst
    |=> CLR_IMASK && q.lp == LP_STOP && q.cnt == 12'h000)
    else $error("stop entry wrong");

  wait_cpu_off_a: assert property (
    q.lp == LP_WAIT |-> !CPU_CLK_EN && BASE_CLK_EN)
    else $error("clock enables wrong in wait");

  run_clk_a: assert property (
    q.lp == LP_RUN |-> CPU_CLK_EN && BASE_CLK_EN)
    else $error("clock gated while running");

  wait_wake_a: assert property (
    q.lp == LP_WAIT && MOD_IRQ && !any_rst
    |=> STACK_GO && CPU_CLK_EN)
    else $error("wait wake not one cycle");

  stack_pulse_a: assert property (
    STACK_GO |=> !STACK_GO)
    else $error("stacking start longer than one cycle");

  wait_rst_a: assert property (
    q.lp == LP_WAIT && any_rst |=> q.lp == LP_RUN && !STACK_GO)
    else $error("reset did not end wait cleanly");

  wait_brk_a: assert property (
    q.lp == LP_WAIT && BRK_IRQ && !any_rst
    |=> q.exit_flag && STACK_GO)
    else $error("break in wait mishandled");

  wdog_wait_a: assert property (
    !WDOG_DISABLE && q.lp == LP_WAIT |=> WDOG_RUN)
    else $error("watchdog stopped in wait");

  wdog_off_a: assert property (
    WDOG_DISABLE |=> !WDOG_RUN)
    else $error("watchdog runs while disabled");

  stop_gate_a: assert property (
    q.lp == LP_STOP |-> !BASE_CLK_EN && q.cnt == 12'h000)
    else $error("stop clock or counter wrong");

  stop_cpu_off_a: assert property (
    q.lp == LP_STOP || q.lp == LP_RECOV
    |-> !CPU_CLK_EN && !BASE_CLK_EN)
    else $error("clock running in stop");

  stop_wake_a: assert property (
    q.lp == LP_STOP && (MOD_IRQ || BRK_IRQ) && !any_rst
    |=> q.lp == LP_RECOV && q.cnt == 12'h000 && !STACK_GO)
    else $error("stop wake did not start recovery");

  stop_rst_a: assert property (
    (q.lp == LP_STOP || q.lp == LP_RECOV) && any_rst
    |=> q.lp == LP_RUN && !STACK_GO)
    else $error("reset did not end stop cleanly");

  short_recov_a: assert property (
    q.lp == LP_STOP && MOD_IRQ && !any_rst && SHORT_RECOV_SEL
    |-> (##[1:32] any_rst) or (##33 STACK_GO))
    else $error("short recovery not 32 cycles");

  no_early_stack_a: assert property (
    q.lp == LP_RECOV && !STACK_GO |=> !STACK_GO || $past(q.cnt) ==
      (q.lim_short ? RECOV_SHORT_LAST : RECOV_LONG_LAST))
    else $error("stacking before recovery end");

  recov_count_a: assert property (
    q.lp == LP_RECOV && !any_rst && q.cnt < RECOV_SHORT_LAST
    |=> q.lp == LP_RECOV && q.cnt == $past(q.cnt) + 12'h001)
    else $error("recovery counter not counting");

  run_brk_a: assert property (
    q.lp == LP_RUN && !wr_go |=> $stable(q.exit_flag))
    else $error("exit flag changed while running");

  stop_brk_a: assert property (
    q.lp == LP_STOP && BRK_IRQ && !any_rst |=> q.exit_flag)
    else $error("break in stop did not set flag");

  exit_clr_a: assert property (
    wr_go && q.aw_addr == ADDR_BRK_STAT && strb_ok(q.w_strb)
    && !q.w_data[BIT_BRK_EXIT] && q.lp == LP_RUN |=> !q.exit_flag)
    else $error("exit flag not cleared by write");

  exit_hold_a: assert property (
    q.exit_flag && !wr_go |=> q.exit_flag)
    else $error("exit flag lost without write");

  cause_rd_a: assert property (
    rd_go && AXI_REQ.araddr == ADDR_RST_CAUSE
    && cause_set == 8'h00 |=> q.cause == 8'h00)
    else $error("cause not cleared on read");

  cause_rdata_a: assert property (
    rd_go && AXI_REQ.araddr == ADDR_RST_CAUSE
    |=> AXI_RSP.rdata[7:0] == $past(q.cause))
    else $error("cause read data wrong");

  cause_keep_a: assert property (
    !rd_go |=> (q.cause | $past(q.cause)) == q.cause)
    else $error("cause flag lost without read");

  pin_cause_a: assert property (
    pin_rst |=> q.cause[CA_PIN])
    else $error("pin reset not recorded");

  pin_pull_a: assert property (
    int_rst |=> RST_PIN_OE [*8])
    else $error("reset pin not pulled");
endmodule

/* File: include/slbrs_pkg.sv */
package slbrs_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_BRK_STAT  = 12'h000;
  localparam logic [11:0] ADDR_RST_CAUSE = 12'h004;
  localparam logic [11:0] ADDR_BRK_CTRL  = 12'h008;
  // Field positions
  localparam int BIT_BRK_EXIT = 0;
  localparam int BIT_BREAK_CLEAR_ENABLE     = 0;
  localparam int CA_POR       = 7;
  localparam int CA_PIN       = 6;
  localparam int CA_WDOG      = 5;
  localparam int CA_OPC       = 4;
  localparam int CA_FETCH     = 3;
  localparam int CA_LV        = 1;
  // Reset values
  localparam logic [7:0] RST_CAUSE_VAL = 8'h80;
  localparam logic       RST_BREAK_CLEAR_ENABLE_VAL  = 1'b0;
  localparam logic       RST_EXIT_VAL  = 1'b0;
  // Recovery delays in oscillator cycles
  localparam int RECOV_LONG_CYC  = 4096;
  localparam int RECOV_SHORT_CYC = 32;
  localparam logic [11:0] RECOV_LONG_LAST  = 12'(RECOV_LONG_CYC - 1);
  localparam logic [11:0] RECOV_SHORT_LAST = 12'(RECOV_SHORT_CYC - 1);
  // Reset pin pull-down length in cycles
  localparam int PIN_PULL_CYC = 32;
  // Counter outlives the drive by the pin synchroniser depth
  localparam int PIN_SYNC_CYC = 2;
  localparam logic [5:0] PIN_PULL_LOAD = 6'(PIN_PULL_CYC + PIN_SYNC_CYC);
  localparam logic [5:0] PIN_OE_TAIL   = 6'(PIN_SYNC_CYC);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {LP_RUN, LP_WAIT, LP_STOP, LP_RECOV} slbrs_lp_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } slbrs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } slbrs_axi_rsp_t;

  typedef struct packed {
    logic            pin_s1;
    logic            pin_s2;
    slbrs_lp_t       lp;
    logic [11:0]     cnt;
    logic            lim_short;
    logic            wake_irq;
    logic            exit_flag;
    logic [7:0]      cause;
    logic            break_clear_enable;
    logic            clr_allow;
    logic            cpu_clk_en;
    logic            base_clk_en;
    logic            clr_imask;
    logic            stack_go;
    logic            wdog_run;
    logic [5:0]      pull;
    logic            rst_oe;
    logic            aw_held;
    logic [11:0]     aw_addr;
    logic            w_held;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    slbrs_axi_rsp_t  rsp;
  } slbrs_st_t;
endpackage

/* File: test/slbrs_core_model.sv */
`timescale 1ns/1ps
module slbrs_core_model
  import slbrs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_hold,
  input  wire logic canned_osc,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic clr_imask,
  input  wire logic stack_go,
  output logic      pin_i,
  output logic      short_sel,
  output logic      imask_q
);
  // Pull-up on the pin: released reads high, any driver pulls low
  assign pin_i = ~pin_hold & (pin_oe ? pin_o : 1'b1);
  // Crystal parts keep the long recovery; short only for canned
  assign short_sel = canned_osc;
  // Mask bit of the core: stacking sets it, low-power entry clears
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      imask_q <= 1'b1;
    else if (stack_go)
      imask_q <= 1'b1;
    else if (clr_imask)
      imask_q <= 1'b0;
  end
endmodule

/* File: test/slbrs_top_test.sv */
`timescale 1ns/1ps
module slbrs_top_test;
  import slbrs_pkg::*;
  logic           clk = 0;
  logic           rst = 1;
  slbrs_axi_req_t rq  = '0;
  slbrs_axi_rsp_t rs;
  logic [8:0]     ev  = '0;
  logic           bm  = 0;
  logic           co  = 0;
  logic           wd  = 0;
  logic           ss, pi, fca, cen, ben, cim, sg, wrun, po, poe, im;
  logic [31:0]    d, v;
  logic [1:0]     r;
  logic           break_clear_enable_m, exit_m;
  int             error_cnt = 0;
  int             comparisons = 0;
  int             cyc = 0;
  int             n, seed;
  int             src[5] = '{3, 4, 5, 6, 8};
  int             cbit[5] = '{CA_WDOG, CA_OPC, CA_FETCH, CA_LV, CA_PIN};

  slbrs_top i_dut (
    .CLK(clk), .RST(rst), .AXI_REQ(rq), .AXI_RSP(rs),
    .WAIT_EXEC(ev[0]), .STOP_EXEC(ev[1]), .MOD_IRQ(ev[7]),
    .BRK_IRQ(ev[2]), .BRK_MODE(bm), .SHORT_RECOV_SEL(ss),
    .WDOG_DISABLE(wd), .RST_PIN_I(pi), .WDOG_RST(ev[3]),
    .BAD_OPCODE(ev[4]), .BAD_FETCH(ev[5]), .LOW_VOLT(ev[6]),
    .FLAG_CLR_ALLOW(fca), .CPU_CLK_EN(cen), .BASE_CLK_EN(ben),
    .CLR_IMASK(cim), .STACK_GO(sg), .WDOG_RUN(wrun),
    .RST_PIN_O(po), .RST_PIN_OE(poe));

  slbrs_core_model i_core (
    .clk(clk), .rst(rst), .pin_hold(ev[8]), .canned_osc(co),
    .pin_o(po), .pin_oe(poe), .clr_imask(cim), .stack_go(sg),
    .pin_i(pi), .short_sel(ss), .imask_q(im));

  always #10 clk = ~clk;

  // Longest path is the 4096-cycle recovery; generous ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic tk(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dd);
    @(posedge clk);
    rq.awvalid <= 1;
    rq.awaddr  <= a;
    rq.wvalid  <= 1;
    rq.wdata   <= dd;
    rq.wstrb   <= 4'hf;
    rq.bready  <= 1;
    do
    begin
      @(posedge clk);
      rq.awvalid <= rq.awvalid & ~rs.awready;
      rq.wvalid  <= rq.wvalid & ~rs.wready;
    end while (rs.bvalid !== 1'b1);
    r = rs.bresp;
    rq.bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    rq.arvalid <= 1;
    rq.araddr  <= a;
    rq.rready  <= 1;
    do
    begin
      @(posedge clk);
      rq.arvalid <= rq.arvalid & ~rs.arready;
    end while (rs.rvalid !== 1'b1);
    v = rs.rdata;
    r = rs.rresp;
    rq.rready <= 0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic pulse(input int i, input int k);
    @(posedge clk) ev[i] <= 1;
    tk(k);
    ev[i] <= 0;
  endtask

  // Counts edges from the wake request until stacking starts
  task automatic wake(input int i);
    @(posedge clk) ev[i] <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (sg !== 1'b1);
    @(posedge clk) ev[i] <= 0;
  endtask

  initial
  begin
    seed = 32'h3c89_b87d;
    tk(10);
    @(posedge clk) rst <= 0;
    tk(3);
    rchk(ADDR_RST_CAUSE, 32'(RST_CAUSE_VAL));
    rchk(ADDR_RST_CAUSE, 32'h0000_0000);
    rchk(ADDR_BRK_STAT, 32'h0000_0000);
    rchk(ADDR_BRK_CTRL, 32'h0000_0000);
    wr(12'h00c, $random(seed));
    chk(32'(r), 32'(RESP_SLVERR));
    rd(12'h00c);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("registers done");
    for (int i = 0; i < 2; i++)
    begin
      d = $random(seed);
      d[0] = i[0];
      wr(ADDR_BRK_CTRL, d);
      break_clear_enable_m = d[0];
      rchk(ADDR_BRK_CTRL, 32'(break_clear_enable_m));
      @(posedge clk) bm <= 1;
      tk(2);
      #1 chk(32'(fca), 32'(break_clear_enable_m));
      @(posedge clk) bm <= 0;
      tk(2);
      #1 chk(32'(fca), 32'h0000_0001);
    end
    $display("break protection done");
    pulse(2, 1);
    tk(2);
    rchk(ADDR_BRK_STAT, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk) wd <= i[0];
      pulse(0, 1);
      #1 chk(32'(cim), 32'h0000_0001);
      tk(1);
      #1 chk({cen, ben, wrun, im}, {2'b01, ~i[0], 1'b0});
      tk(1 + ($random(seed) & 3));
      wake(i ? 2 : 7);
      chk(32'(n), 32'h0000_0001);
      exit_m = i[0];
      rchk(ADDR_BRK_STAT, 32'(exit_m));
      wr(ADDR_BRK_STAT, 32'h0000_0000);
      rchk(ADDR_BRK_STAT, 32'h0000_0000);
    end
    $display("wait done");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk) co <= ~i[0];
      pulse(1, 1);
      #1 chk(32'(cim), 32'h0000_0001);
      tk(1);
      #1 chk({cen, ben, wrun, im}, 4'b0000);
      wake(i ? 2 : 7);
      chk(n, 1 + (i ? RECOV_LONG_CYC : RECOV_SHORT_CYC));
      #1 chk({cen, ben}, 2'b11);
      exit_m = i[0];
      rchk(ADDR_BRK_STAT, 32'(exit_m));
    end
    @(posedge clk) rst <= 1;
    tk(2);
    @(posedge clk) rst <= 0;
    tk(3);
    rchk(ADDR_BRK_STAT, 32'h0000_0000);
    rchk(ADDR_RST_CAUSE, 32'(RST_CAUSE_VAL));
    $display("stop done");
    foreach (src[j])
    begin
      pulse(0, 1);
      tk(2);
      pulse(src[j], 3);
      #1 chk(32'(poe), 32'(src[j] != 8));
      tk(40);
      #1 chk({cen, im}, 2'b10);
      rchk(ADDR_RST_CAUSE, 32'(1) << cbit[j]);
      rchk(ADDR_RST_CAUSE, 32'h0000_0000);
    end
    pulse(3, 1);
    pulse(6, 1);
    tk(40);
    rchk(ADDR_RST_CAUSE, (32'(1) << CA_WDOG) | (32'(1) << CA_LV));
    $display("reset causes done");
    tally_and_finish;
  end
endmodule
